/* File: hw/rbpd_consts.vh */
// Constants for the RAM back-up power-down sequencer.
// Included by the sequencer; holds definitions only.
`ifndef RBPD_CONSTS_VH
`define RBPD_CONSTS_VH
// Reset value of the program counter (page 0, address 0)
`define RBPD_PC_RESET 14'h0000
// Reset value of the output port latches after a cold start
`define RBPD_PORT_RESET 4'hf
// Reset value for every 4-bit control register
`define RBPD_REG4_RESET 4'h0
// Width of the control register select code
`define RBPD_SEL_W 4
// Register select codes for the control-register write port
`define RBPD_SEL_TCTL1 4'h0
`define RBPD_SEL_TCTL2 4'h1
`define RBPD_SEL_TCTL6 4'h2
`define RBPD_SEL_CLK 4'h3
`define RBPD_SEL_IEN1 4'h4
`define RBPD_SEL_IEN2 4'h5
`define RBPD_SEL_EXT1 4'h6
`define RBPD_SEL_EXT2 4'h7
`define RBPD_SEL_SER 4'h8
`define RBPD_SEL_CMP 4'h9
`define RBPD_SEL_WAKE 4'ha
`define RBPD_SEL_PULL 4'hb
`define RBPD_SEL_PORT 4'hc
`define RBPD_SEL_TCTL34 4'hd
`define RBPD_SEL_CONV 4'he
// Register read address for the status word
`define RBPD_RD_STATUS 4'hf
`endif

/* File: hw/rbpd_seq.v */
// RAM back-up power-down sequencer of a small 4-bit microcontroller.
// Assumes one 10 MHz system clock, a decoder that pulses one instruction
// strobe per executed instruction, and asynchronous reset and wake pins.
//
// Overview of operation
// - Supply-drop detection resets the whole controller
// - Back-up only on enable then power-off
// - Lone power-off acts as no-operation
// - Back-up stops oscillator, keeps RAM, reset
// - Skip instruction tests the power-down flag
// - Wakeup restarts at zero, flag set
// - Cold reset restarts at zero, flag cleared
// - RAM and output port levels retained
// - CPU working registers reset on wakeup
// - Timer controls two-four, six kept; one reset
// - Clock and interrupt-enable controls reset
// - External interrupt controls kept
// - Timer, conversion, serial stop, no resume
// - Serial mode register kept
// - Comparator function kept through back-up
// - Request, watchdog, done flags reset
// - Wakeup and pull-up controls kept
`include "rbpd_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module rbpd_seq #(
    parameter PC_W = 14 // Program counter width
) (
    input wire i_clock, // System clock, 10 MHz
    input wire i_rst, // Synchronous reset, active high
    input wire i_reset_pin_n, // Reset pin, active low, asynchronous
    input wire i_wdt_reset, // Watchdog reset request, same clock
    input wire i_vdrop, // Supply-drop detector output, asynchronous
    input wire i_wakeup, // External wakeup input, asynchronous
    input wire i_instr_valid, // One pulse per executed instruction
    input wire i_is_pof_en, // Executed instruction is power_off_enable_instr
    input wire i_is_pof, // Executed instruction is power_off_instr
    input wire i_is_skip_if_powerdown_flag_instr, // Executed instruction is skip_if_powerdown_flag_instr
    input wire i_reg_wr, // Control register write strobe
    input wire [3:0] i_reg_sel, // Control register select
    input wire [3:0] i_reg_wdata, // Control register write data
    input wire i_rd, // Read strobe
    input wire [3:0] i_rd_addr, // Read address
    input wire [3:0] i_port_d, // Output port level to drive
    input wire i_port_wr, // Output port write strobe
    input wire i_tmr_run, // Timers request to count
    input wire i_conv_run, // Converter requests to convert
    input wire i_ser_run, // Serial unit requests to shift
    output reg [3:0] o_rd_data, // Read data, one cycle after strobe
    output reg o_osc_en, // Oscillator enable, low in back-up
    output reg o_backup, // High while in back-up
    output reg o_cpu_reset, // Pulse: reinit PC, A, B, carry, stack
    output reg [PC_W-1:0] o_pc_start, // Restart address
    output reg o_pd_flag, // Power-down flag
    output reg o_skip, // Skip next instruction
    output reg o_flags_clr, // Pulse: clear request, watchdog, done flags
    output reg o_tmr_en, // Timers may count
    output reg o_conv_en, // Converter may run
    output reg o_ser_en, // Serial unit may run
    output reg o_cmp_en, // Comparator kept enabled
    output reg [3:0] o_port_q, // Retained output port level
    output reg [3:0] o_tctl_one, // timer_ctrl_one
    output reg [3:0] o_tctl_two, // timer_ctrl_two
    output reg [3:0] o_tctl_six, // timer_ctrl_six
    output reg [3:0] o_clk_ctrl, // clock_ctrl_reg
    output reg [3:0] o_ien_one, // int_enable_ctrl_one
    output reg [3:0] o_ien_two, // int_enable_ctrl_two
    output reg [3:0] o_ext_one, // ext_int_ctrl_one
    output reg [3:0] o_ext_two // ext_int_ctrl_two
);

    // One-hot sequencer states
    localparam [2:0] ST_RUN = 3'b001;
    localparam [2:0] ST_BACKUP = 3'b010;
    localparam [2:0] ST_WAKE = 3'b100;

    // Synchroniser chains for the pins; index 2 is the oldest stage
    reg [2:0] rst_sync_q; // Reset pin, active-low samples
    reg [2:0] drop_sync_q; // Supply-drop samples
    reg [2:0] wake_sync_q; // Wakeup samples
    reg rst_pin_q; // Filtered reset pin (1 = asserted)
    reg drop_q; // Filtered supply drop
    reg wake_q; // Filtered wakeup level

    reg [2:0] state_q; // Sequencer state
    reg armed_q; // Previous instruction was power_off_enable_instr
    reg [3:0] serial_mode_q; // serial_mode_reg
    reg [3:0] cmp_ctrl_q; // comparator_ctrl
    reg [3:0] wake_ctrl_q; // wakeup_ctrl_reg
    reg [3:0] pull_ctrl_q; // pullup_ctrl_reg
    reg [3:0] port_dir_q; // port_direction_reg
    reg [3:0] tctl34_q; // Timer controls three and four, packed
    reg [3:0] conv_ctrl_q; // conv_ctrl_one
    reg run_gate_q; // Peripherals allowed after a start

    wire cold; // Any cold-start cause
    wire pof_ok; // Power-off accepted

    // Pin synchronisers: a level change counts once stages 1 and 2 agree
    // Three stages rather than two: the agreement test filters a single-cycle
    // glitch on a pin, at the cost of one more cycle of latency
    // The reset branch loads each chain with its pin's idle level, so that
    // no false edge is seen in the first cycles after reset
    always @(posedge i_clock) begin
        if (i_rst) begin
            rst_sync_q <= 3'b111;
            drop_sync_q <= 3'b000;
            wake_sync_q <= 3'b000;
            rst_pin_q <= 1'b0;
            drop_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            rst_sync_q <= {rst_sync_q[1:0], i_reset_pin_n};
            drop_sync_q <= {drop_sync_q[1:0], i_vdrop};
            wake_sync_q <= {wake_sync_q[1:0], i_wakeup};
            if (rst_sync_q[1] == rst_sync_q[2]) begin
                rst_pin_q <= ~rst_sync_q[2];
            end
            if (drop_sync_q[1] == drop_sync_q[2]) begin
                drop_q <= drop_sync_q[2];
            end
            if (wake_sync_q[1] == wake_sync_q[2]) begin
                wake_q <= wake_sync_q[2];
            end
        end
    end

    // Cold causes: reset pin, watchdog, supply drop
    // Pin and drop causes arrive some four cycles late through the filter;
    // the watchdog request is already on this clock and acts at once
    assign cold = i_rst | rst_pin_q | i_wdt_reset | drop_q;
    // Power-off only counts straight after the enable instruction
    assign pof_ok = i_instr_valid & i_is_pof & armed_q;

    // Sequencer and CPU-facing start controls
    always @(posedge i_clock) begin
        if (cold) begin
            // Full cold reset; every element to its reset value
            state_q <= ST_RUN;
            armed_q <= 1'b0;
            o_osc_en <= 1'b1;
            o_backup <= 1'b0;
            o_cpu_reset <= 1'b1;
            o_pc_start <= {PC_W{1'b0}};
            o_pd_flag <= 1'b0;
            o_skip <= 1'b0;
            o_flags_clr <= 1'b1;
            run_gate_q <= 1'b0;
        end else begin
            o_cpu_reset <= 1'b0;
            o_flags_clr <= 1'b0;
            o_skip <= 1'b0;
            case (state_q)
                ST_RUN: begin
                    if (i_instr_valid) begin
                        // Any other instruction breaks the pair
                        armed_q <= i_is_pof_en;
                        if (i_is_skip_if_powerdown_flag_instr) begin
                            o_skip <= o_pd_flag;
                        end
                    end
                    if (pof_ok) begin
                        state_q <= ST_BACKUP;
                        o_osc_en <= 1'b0;
                        o_backup <= 1'b1;
                        run_gate_q <= 1'b0;
                        armed_q <= 1'b0;
                    end else if (i_instr_valid | i_reg_wr) begin
                        // A software start re-allows peripherals
                        run_gate_q <= 1'b1;
                    end
                end
                ST_BACKUP: begin
                    // Clock is treated as stopped; only wake or cold act
                    // Instructions and writes are ignored here, since the
                    // real core is frozen while the oscillator is off
                    if (wake_q) begin
                        state_q <= ST_WAKE;
                        o_osc_en <= 1'b1;
                    end
                end
                ST_WAKE: begin
                    // Warm start: reinit CPU and flags, flag set
                    // Lasts one cycle; the lost registers are cleared on the
                    // same edge by their own process
                    state_q <= ST_RUN;
                    o_backup <= 1'b0;
                    o_cpu_reset <= 1'b1;
                    o_flags_clr <= 1'b1;
                    o_pc_start <= {PC_W{1'b0}};
                    o_pd_flag <= 1'b1;
                end
                default: begin
                    state_q <= ST_RUN;
                end
            endcase
        end
    end

    // Peripheral run enables; nothing resumes until software acts again
    // The accepted power-off also clears them, so that no enable is left
    // high in the first cycle of back-up
    always @(posedge i_clock) begin
        if (cold | o_backup | pof_ok) begin
            o_tmr_en <= 1'b0;
            o_conv_en <= 1'b0;
            o_ser_en <= 1'b0;
        end else begin
            o_tmr_en <= i_tmr_run & run_gate_q;
            o_conv_en <= i_conv_run & run_gate_q;
            o_ser_en <= i_ser_run & run_gate_q;
        end
    end

    // Registers lost across back-up: reset on cold and on warm start
    // Writes in back-up are dropped: the core issuing them is stopped
    always @(posedge i_clock) begin
        if (cold | (state_q == ST_WAKE)) begin
            o_tctl_one <= `RBPD_REG4_RESET;
            o_clk_ctrl <= `RBPD_REG4_RESET;
            o_ien_one <= `RBPD_REG4_RESET;
            o_ien_two <= `RBPD_REG4_RESET;
            conv_ctrl_q <= `RBPD_REG4_RESET;
        end else if (i_reg_wr & ~o_backup) begin
            if (i_reg_sel == `RBPD_SEL_TCTL1) begin
                o_tctl_one <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_CLK) begin
                o_clk_ctrl <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_IEN1) begin
                o_ien_one <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_IEN2) begin
                o_ien_two <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_CONV) begin
                conv_ctrl_q <= i_reg_wdata;
            end
        end
    end

    // Registers kept across back-up: only a cold start resets them
    always @(posedge i_clock) begin
        if (cold) begin
            o_tctl_two <= `RBPD_REG4_RESET;
            o_tctl_six <= `RBPD_REG4_RESET;
            tctl34_q <= `RBPD_REG4_RESET;
            o_ext_one <= `RBPD_REG4_RESET;
            o_ext_two <= `RBPD_REG4_RESET;
            serial_mode_q <= `RBPD_REG4_RESET;
            cmp_ctrl_q <= `RBPD_REG4_RESET;
            wake_ctrl_q <= `RBPD_REG4_RESET;
            pull_ctrl_q <= `RBPD_REG4_RESET;
            port_dir_q <= `RBPD_REG4_RESET;
        end else if (i_reg_wr & ~o_backup) begin
            if (i_reg_sel == `RBPD_SEL_TCTL2) begin
                o_tctl_two <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_TCTL6) begin
                o_tctl_six <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_TCTL34) begin
                tctl34_q <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_EXT1) begin
                o_ext_one <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_EXT2) begin
                o_ext_two <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_SER) begin
                serial_mode_q <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_CMP) begin
                cmp_ctrl_q <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_WAKE) begin
                wake_ctrl_q <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_PULL) begin
                pull_ctrl_q <= i_reg_wdata;
            end else if (i_reg_sel == `RBPD_SEL_PORT) begin
                port_dir_q <= i_reg_wdata;
            end
        end
    end

    // Port level and comparator enable survive back-up untouched
    always @(posedge i_clock) begin
        if (cold) begin
            // Output latches come up set after a cold start
            o_port_q <= `RBPD_PORT_RESET;
            o_cmp_en <= 1'b0;
        end else begin
            if (i_port_wr & ~o_backup) begin
                o_port_q <= i_port_d;
            end
            // Comparator stays on in back-up as software left it
            o_cmp_en <= |cmp_ctrl_q;
        end
    end

    // Read port: data valid in the cycle after the strobe only
    // Returning zero outside that cycle keeps stale data from being mistaken
    // for a fresh answer; reads work during back-up and during every cold reset except i_rst, which returns zero
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_rd_data <= 4'h0;
        end else if (i_rd) begin
            if (i_rd_addr == `RBPD_SEL_TCTL1) begin
                o_rd_data <= o_tctl_one;
            end else if (i_rd_addr == `RBPD_SEL_TCTL2) begin
                o_rd_data <= o_tctl_two;
            end else if (i_rd_addr == `RBPD_SEL_TCTL6) begin
                o_rd_data <= o_tctl_six;
            end else if (i_rd_addr == `RBPD_SEL_CLK) begin
                o_rd_data <= o_clk_ctrl;
            end else if (i_rd_addr == `RBPD_SEL_IEN1) begin
                o_rd_data <= o_ien_one;
            end else if (i_rd_addr == `RBPD_SEL_IEN2) begin
                o_rd_data <= o_ien_two;
            end else if (i_rd_addr == `RBPD_SEL_EXT1) begin
                o_rd_data <= o_ext_one;
            end else if (i_rd_addr == `RBPD_SEL_EXT2) begin
                o_rd_data <= o_ext_two;
            end else if (i_rd_addr == `RBPD_SEL_SER) begin
                o_rd_data <= serial_mode_q;
            end else if (i_rd_addr == `RBPD_SEL_CMP) begin
                o_rd_data <= cmp_ctrl_q;
            end else if (i_rd_addr == `RBPD_SEL_WAKE) begin
                o_rd_data <= wake_ctrl_q;
            end else if (i_rd_addr == `RBPD_SEL_PULL) begin
                o_rd_data <= pull_ctrl_q;
            end else if (i_rd_addr == `RBPD_SEL_PORT) begin
                o_rd_data <= port_dir_q;
            end else if (i_rd_addr == `RBPD_SEL_TCTL34) begin
                o_rd_data <= tctl34_q;
            end else if (i_rd_addr == `RBPD_SEL_CONV) begin
                o_rd_data <= conv_ctrl_q;
            end else begin
                // Status: power-down flag, back-up, armed, run gate
                o_rd_data <= {run_gate_q, armed_q, o_backup, o_pd_flag};
            end
        end else begin
            o_rd_data <= 4'h0;
        end
    end

endmodule

`default_nettype wire

/* File: dv/rbpd_seq_assertions.sv */
// Checker for the back-up sequencer, bound to its top-level ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "rbpd_consts.vh"
module rbpd_seq_checker #(
    parameter PC_W = 14 // Program counter width
) (
    input wire i_clock, // Clock
    input wire i_rst, // Reset
    input wire i_wdt_reset, // Watchdog reset
    input wire i_instr_valid, // Instruction strobe
    input wire i_is_pof_en, // Enable instruction
    input wire i_is_pof, // Power-off instruction
    input wire i_is_skip_if_powerdown_flag_instr, // Skip instruction
    input wire o_osc_en, // Oscillator enable
    input wire o_backup, // Back-up state
    input wire o_cpu_reset, // CPU reinit pulse
    input wire [PC_W-1:0] o_pc_start, // Restart address
    input wire o_pd_flag, // Power-down flag
    input wire o_skip, // Skip pulse
    input wire o_flags_clr, // Flag clear pulse
    input wire o_tmr_en, // Timer enable
    input wire [3:0] o_port_q, // Port level
    input wire [3:0] o_tctl_one, // Lost timer control
    input wire [3:0] o_tctl_two, // Kept timer control
    input wire [3:0] o_clk_ctrl, // Clock control
    input wire [3:0] o_ien_one, // Interrupt enable
    input wire [3:0] o_ext_one // External interrupt control
);
    // Last executed instruction was the enable; idle cycles keep it
    reg armed_q;
    always @(posedge i_clock) begin
        if (i_rst || i_wdt_reset)
            armed_q <= 1'b0;
        else if (i_instr_valid)
            armed_q <= i_is_pof_en;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    enter_backup_a: assert property (i_instr_valid && i_is_pof && armed_q
        && !i_wdt_reset |=> o_backup && !o_osc_en) else $error("back-up not entered");
    backup_cause_a: assert property ($rose(o_backup)
        |-> $past(i_instr_valid && i_is_pof && armed_q)) else $error("back-up without cause");
    pof_alone_a: assert property (i_instr_valid && i_is_pof && !armed_q && !o_backup
        && !i_wdt_reset |=> !o_backup && $stable(o_pd_flag)) else $error("lone power-off acted");
    osc_stop_a: assert property ($rose(o_backup)
        |-> !o_osc_en && !o_tmr_en) else $error("clock or timer runs in back-up");
    wake_step_a: assert property ($rose(o_osc_en) && o_backup |=> !o_backup && o_pd_flag
        && o_cpu_reset && o_flags_clr && o_pc_start == `RBPD_PC_RESET) else $error("bad wake");
    warm_lost_a: assert property ($fell(o_backup) && o_pd_flag |-> o_tctl_one == 4'h0
        && o_clk_ctrl == 4'h0 && o_ien_one == 4'h0) else $error("lost register kept");
    warm_kept_a: assert property ($fell(o_backup) && o_pd_flag |-> $stable(o_tctl_two)
        && $stable(o_ext_one) && $stable(o_port_q)) else $error("kept register changed");
    held_regs_a: assert property (o_backup && $past(o_backup) |-> $stable(o_port_q)
        && $stable(o_tctl_two) && $stable(o_tctl_one)) else $error("state moved in back-up");
    cold_start_a: assert property (disable iff (1'b0) i_rst || i_wdt_reset
        |=> !o_pd_flag && o_cpu_reset && !o_backup && o_port_q == `RBPD_PORT_RESET)
        else $error("bad cold");
    skip_flag_a: assert property (i_instr_valid && i_is_skip_if_powerdown_flag_instr
        |=> o_skip == $past(o_pd_flag)) else $error("skip does not follow flag");
    skip_cause_a: assert property (o_skip
        |-> $past(i_instr_valid && i_is_skip_if_powerdown_flag_instr && o_pd_flag)) else $error("stray skip");
endmodule
bind rbpd_seq rbpd_seq_checker #(.PC_W(PC_W)) i_chk (
    .i_clock(i_clock), .i_rst(i_rst), .i_wdt_reset(i_wdt_reset), .i_instr_valid(i_instr_valid),
    .i_is_pof_en(i_is_pof_en), .i_is_pof(i_is_pof), .i_is_skip_if_powerdown_flag_instr(i_is_skip_if_powerdown_flag_instr), .o_osc_en(o_osc_en),
    .o_backup(o_backup), .o_cpu_reset(o_cpu_reset), .o_pc_start(o_pc_start),
    .o_pd_flag(o_pd_flag), .o_skip(o_skip), .o_flags_clr(o_flags_clr), .o_tmr_en(o_tmr_en),
    .o_port_q(o_port_q), .o_tctl_one(o_tctl_one), .o_tctl_two(o_tctl_two),
    .o_clk_ctrl(o_clk_ctrl), .o_ien_one(o_ien_one), .o_ext_one(o_ext_one));
`default_nettype wire

/* File: dv/rbpd_far_side.sv */
// Far side of the sequencer: wake pin, reset pin, supply-drop detector.
// Assumes the bench raises command levels; pins follow each clock edge 37 ns later.
`timescale 1ns/1ps
`default_nettype none
module rbpd_far_side (
    input wire i_clock, // Paces the pins only
    input wire i_wake_cmd, // Bench asks for wakeup
    input wire i_pin_cmd, // Bench asks for reset pin
    input wire i_drop_cmd, // Bench asks for supply drop
    output reg o_wakeup = 1'b0, // Wakeup pin
    output reg o_reset_pin_n = 1'b1, // Reset pin, active low
    output reg o_vdrop = 1'b0 // Drop detector output
);
    // Odd lag so the synchronisers see a truly asynchronous edge
    always @(posedge i_clock) begin
        o_wakeup <= #37 i_wake_cmd;
        o_reset_pin_n <= #37 !i_pin_cmd;
        o_vdrop <= #37 i_drop_cmd;
    end
endmodule
`default_nettype wire

/* File: dv/ram_backup_power_down_ctrl_test.sv */
// Self-checking bench for the back-up sequencer against an integer model.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module ram_backup_power_down_ctrl_test;
    reg i_clock = 1'b0, i_rst = 1'b1, i_wdt_reset = 1'b0, i_instr_valid = 1'b0;
    reg i_is_pof_en = 1'b0, i_is_pof = 1'b0, i_is_skip_if_powerdown_flag_instr = 1'b0, i_reg_wr = 1'b0, i_rd = 1'b0;
    reg i_port_wr = 1'b0, wake_cmd = 1'b0, pin_cmd = 1'b0, drop_cmd = 1'b0;
    reg [2:0] run_req = 3'h7; // Timer, converter, serial run requests
    reg [3:0] i_reg_sel = 4'h0, i_reg_wdata = 4'h0, i_rd_addr = 4'h0, i_port_d = 4'h0, rdata;
    wire wakeup, reset_pin_n, vdrop, o_osc_en, o_backup, o_cpu_reset, o_pd_flag, o_skip;
    wire o_flags_clr, o_tmr_en, o_conv_en, o_ser_en, o_cmp_en;
    wire [3:0] o_rd_data, o_port_q, o_tctl_one, o_tctl_two, o_tctl_six, o_clk_ctrl;
    wire [3:0] o_ien_one, o_ien_two, o_ext_one, o_ext_two;
    wire [13:0] o_pc_start;
    integer exp_reg [0:15]; // Model of the control registers
    integer exp_port, exp_flag, exp_bk, fails = 0, check_count = 0, k, r;
    always #50 i_clock = ~i_clock;
    rbpd_far_side i_far (.i_clock(i_clock), .i_wake_cmd(wake_cmd), .i_pin_cmd(pin_cmd),
        .i_drop_cmd(drop_cmd), .o_wakeup(wakeup), .o_reset_pin_n(reset_pin_n), .o_vdrop(vdrop));
    rbpd_seq i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_reset_pin_n(reset_pin_n),
        .i_wdt_reset(i_wdt_reset), .i_vdrop(vdrop), .i_wakeup(wakeup),
        .i_instr_valid(i_instr_valid), .i_is_pof_en(i_is_pof_en), .i_is_pof(i_is_pof),
        .i_is_skip_if_powerdown_flag_instr(i_is_skip_if_powerdown_flag_instr), .i_reg_wr(i_reg_wr), .i_reg_sel(i_reg_sel),
        .i_reg_wdata(i_reg_wdata), .i_rd(i_rd), .i_rd_addr(i_rd_addr), .i_port_d(i_port_d),
        .i_port_wr(i_port_wr), .i_tmr_run(run_req[2]), .i_conv_run(run_req[1]),
        .i_ser_run(run_req[0]),
        .o_rd_data(o_rd_data), .o_osc_en(o_osc_en), .o_backup(o_backup),
        .o_cpu_reset(o_cpu_reset), .o_pc_start(o_pc_start), .o_pd_flag(o_pd_flag),
        .o_skip(o_skip), .o_flags_clr(o_flags_clr), .o_tmr_en(o_tmr_en), .o_conv_en(o_conv_en),
        .o_ser_en(o_ser_en), .o_cmp_en(o_cmp_en), .o_port_q(o_port_q), .o_tctl_one(o_tctl_one),
        .o_tctl_two(o_tctl_two), .o_tctl_six(o_tctl_six), .o_clk_ctrl(o_clk_ctrl),
        .o_ien_one(o_ien_one), .o_ien_two(o_ien_two), .o_ext_one(o_ext_one),
        .o_ext_two(o_ext_two));
    // One comparison; an unknown bit matches only an unknown bit
    task chk(input string what, input logic [15:0] seen, input logic [15:0] want);
        check_count = check_count + 1;
        if (seen !== want) begin
            fails = fails + 1;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    // Register write; dropped by the model while in back-up
    task wr(input [3:0] sel, input [3:0] data, input bit port);
        @(posedge i_clock);
        i_reg_wr <= !port;
        i_port_wr <= port;
        i_reg_sel <= sel;
        i_reg_wdata <= data;
        i_port_d <= data;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
        i_port_wr <= 1'b0;
        if (exp_bk == 0 && port) exp_port = data;
        if (exp_bk == 0 && !port) exp_reg[sel] = data;
    endtask
    // Read; data stand only in the cycle after the strobe
    task rd(input [3:0] addr);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_rd_addr <= addr;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        rdata = o_rd_data;
    endtask
    // Kind 0 enable, 1 power-off, 2 skip, 3 any other
    task ins(input [1:0] kind);
        @(posedge i_clock);
        i_instr_valid <= 1'b1;
        i_is_pof_en <= (kind == 2'd0);
        i_is_pof <= (kind == 2'd1);
        i_is_skip_if_powerdown_flag_instr <= (kind == 2'd2);
        @(posedge i_clock);
        {i_instr_valid, i_is_pof_en, i_is_pof, i_is_skip_if_powerdown_flag_instr} <= 4'h0;
        #1;
    endtask
    task model(input bit warm);
        for (k = 0; k < 15; k = k + 1)
            if (!warm || k == 0 || k == 3 || k == 4 || k == 5 || k == 14) exp_reg[k] = 0;
        if (!warm) exp_port = 15;
        exp_flag = warm;
        exp_bk = 0;
    endtask
    task check_all;
        for (k = 0; k < 15; k = k + 1) begin
            rd(k[3:0]);
            chk("register", {12'h000, rdata}, exp_reg[k]);
        end
        rd(4'hf);
        chk("status flag", {15'h0, rdata[0]}, exp_flag);
        chk("port level", {12'h000, o_port_q}, exp_port);
        chk("flag", {15'h0, o_pd_flag}, exp_flag);
        chk("kept outputs", {o_tctl_two, o_tctl_six, o_ext_one, o_ext_two},
            {exp_reg[1][3:0], exp_reg[2][3:0], exp_reg[6][3:0], exp_reg[7][3:0]});
        chk("lost outputs", {o_tctl_one, o_clk_ctrl, o_ien_one, o_ien_two},
            {exp_reg[0][3:0], exp_reg[3][3:0], exp_reg[4][3:0], exp_reg[5][3:0]});
    endtask
    task sleep;
        for (k = 0; k < 16; k = k + 1) wr(k[3:0], $urandom, k == 15);
        run_req <= $urandom;
        ins(0);
        ins(1);
        chk("back-up entry", {14'h0, o_backup, o_osc_en}, 16'h0002);
        chk("sleep enables", {o_tmr_en, o_conv_en, o_ser_en}, 16'h0000);
        exp_bk = 1;
        wr(4'h2, ~exp_reg[2][3:0], 1'b0);
        wr(4'h0, ~exp_port[3:0], 1'b1);
    endtask
    task print_verdict;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #400000;
        fails = fails + 1;
        print_verdict;
    end
    initial begin
        void'($urandom(39131));
        model(1'b0);
        repeat (16) @(posedge i_clock);
        i_rst <= 1'b0;
        check_all;
        chk("restart address", o_pc_start, 16'h0000);
        $display("test cold values done");
        ins(1);
        chk("lone power-off", {15'h0, o_backup}, 16'h0000);
        ins(0);
        ins(3);
        ins(1);
        chk("split pair", {15'h0, o_backup}, 16'h0000);
        ins(2);
        chk("skip cold", {15'h0, o_skip}, 16'h0000);
        $display("test refused power-off done");
        for (r = 0; r < 2; r = r + 1) begin
            sleep;
            wake_cmd <= 1'b1;
            for (k = 0; k < 20 && o_backup !== 1'b0; k = k + 1) @(posedge i_clock) #1;
            chk("wake", {o_cpu_reset, o_flags_clr}, 16'h0003);
            chk("wake enables", {o_tmr_en, o_conv_en, o_ser_en}, 16'h0000);
            chk("wake address", o_pc_start, 16'h0000);
            model(1'b1);
            wake_cmd <= 1'b0;
            chk("comparator", {15'h0, o_cmp_en}, exp_reg[9] != 0);
            ins(2);
            chk("skip warm", {15'h0, o_skip}, 16'h0001);
            check_all;
            chk("run enables", {o_tmr_en, o_conv_en, o_ser_en}, run_req);
        end
        $display("test warm start done");
        for (r = 0; r < 3; r = r + 1) begin
            sleep;
            @(posedge i_clock);
            {drop_cmd, i_wdt_reset, pin_cmd} <= 3'h1 << r;
            repeat (6) @(posedge i_clock);
            #1;
            chk("cold hold", {o_cpu_reset, o_pd_flag, o_backup}, 16'h0004);
            @(posedge i_clock);
            {drop_cmd, i_wdt_reset, pin_cmd} <= 3'h0;
            repeat (8) @(posedge i_clock);
            model(1'b0);
            check_all;
            chk("cold enables", {o_tmr_en, o_conv_en, o_ser_en}, 16'h0000);
        end
        $display("test cold sources done");
        print_verdict;
    end
endmodule
`default_nettype wire
